/* rtl/memory_mode_diag_control.sv */
/*
 * Mode control and diagnostic status register of the memory controller:
 * check-bit substitution, check-bit capture, test and timing mode outputs,
 * soft error logging gate and the external register access timeout.
 * Assumes the processor bus presents one-cycle read/write strobes and that
 * the memory sequencer reports writes, captures and correctable errors.
 */
`timescale 1ns/1ps
`include "mode_diag_params.svh"

// Overview of operation
// - Register sits at one fixed longword address, read and write.
// - Power-up reset clears the register asynchronously.
// - Diagnostic mode substitutes stored check bits on all memory writes.
// - Parity error on substituted write inverts the lowest three check bits.
// - Reserved bit reads zero and ignores writes.
// - Upper field captures read check bits, held until register read.
// - Masked writes never latch check bits into either field.
// - Upper field is read-only and reset clears it to zero until a capture.
// - Lower field returns first captured check bits, held until read.
// - Load pointer starts at lower field, advances per capture, read resets.
// - Fast test bit drives the fast-test select output.
// - Second-pass bit acts only while fast test mode is set.
// - Cache speed bit shifts interface response timing by one cycle.
// - Timer select stretches memory-side timers only.
// - Logging disabled: correct, no interrupt, no log, set lost bits.
// - Logging enabled: correct, interrupt, log and set correctable bits.
// - Prescaler code picks external register timeout of 1.5 to 910 us.
module memory_mode_diag_control #(
    parameter int EPR_CYC_00 = `NS_TO_CYC(`EPR_T00_NS),
    parameter int MEM_TIMER_BASE = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input mode_diag_pkg::bus_req_type bus_req,
    output logic [31:0] rdata,
    output logic rdata_valid,
    input mode_diag_pkg::mem_wr_type mem_wr,
    output logic [6:0] wr_check,
    output logic wr_check_valid,
    input mode_diag_pkg::chk_cap_type chk_cap,
    output logic fast_test_select_out,
    output logic second_pass_out,
    output logic [1:0] cache_resp_cycles,
    output logic [7:0] mem_timer_limit,
    input wire logic ce_event,
    output logic soft_error_irq_n,
    output logic ce_log,
    output logic ce_lost,
    input wire logic epr_start,
    input wire logic epr_done,
    output logic epr_busy,
    output logic epr_timeout
);
    localparam int EPR_CYC_11 = `NS_TO_CYC(`EPR_T11_NS);
    localparam int EPR_CYC_10 = `NS_TO_CYC(`EPR_T10_NS);
    localparam int EPR_CYC_01 = `NS_TO_CYC(`EPR_T01_NS);

    typedef enum logic [1:0] {
        EPR_IDLE_S = 2'b01,
        EPR_WAIT_S = 2'b10
    } epr_state_type;

    logic diag_mode;
    logic [6:0] upper_chk;
    logic [6:0] lower_chk;
    logic fast_test;
    logic second_pass;
    logic cache_slow;
    logic timer_sel;
    logic soft_log;
    logic [1:0] prescale;
    logic load_ptr;
    logic upper_held;
    logic lower_held;
    logic hit;
    logic reg_wr;
    logic reg_rd;
    logic cap_ok;
    logic [31:0] reg_view;
    epr_state_type epr_state;
    logic [19:0] epr_count;
    logic [19:0] epr_limit;

    // Address decode and strobes
    assign hit = bus_req.sel && (bus_req.addr == `MODE_DIAG_ADDR);
    assign reg_wr = hit && bus_req.write;
    assign reg_rd = hit && bus_req.read && !bus_req.write;
    assign cap_ok = chk_cap.valid && !chk_cap.masked;

    // Register image; bits 8:0 belong to other logic and read zero here
    always_comb begin
        reg_view = 32'h0000_0000;
        reg_view[`DIAG_MODE_BIT] = diag_mode;
        reg_view[`RSVD_BIT] = 1'b0;
        reg_view[`UPPER_HI:`UPPER_LO] = upper_chk;
        reg_view[`LOWER_HI:`LOWER_LO] = lower_chk;
        reg_view[`FAST_TEST_BIT] = fast_test;
        reg_view[`SECOND_PASS_BIT] = second_pass;
        reg_view[`CACHE_SPEED_BIT] = cache_slow;
        reg_view[`TIMER_SEL_BIT] = timer_sel;
        reg_view[`SOFT_LOG_BIT] = soft_log;
        reg_view[`PRESCALE_HI:`PRESCALE_LO] = prescale;
    end

    // Read data, registered one cycle after the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 32'h0000_0000;
            rdata_valid <= 1'b0;
        end else begin
            rdata_valid <= reg_rd;
            if (reg_rd) begin
                rdata <= reg_view;
            end
        end
    end

    // Mode bits; the reserved bit has no storage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            diag_mode <= 1'b0;
            fast_test <= 1'b0;
            second_pass <= 1'b0;
            cache_slow <= 1'b0;
            timer_sel <= 1'b0;
            soft_log <= 1'b0;
            prescale <= 2'h0;
        end else if (reg_wr) begin
            diag_mode <= bus_req.wdata[`DIAG_MODE_BIT];
            fast_test <= bus_req.wdata[`FAST_TEST_BIT];
            second_pass <= bus_req.wdata[`SECOND_PASS_BIT];
            cache_slow <= bus_req.wdata[`CACHE_SPEED_BIT];
            timer_sel <= bus_req.wdata[`TIMER_SEL_BIT];
            soft_log <= bus_req.wdata[`SOFT_LOG_BIT];
            prescale <= bus_req.wdata[`PRESCALE_HI:`PRESCALE_LO];
        end
    end

    // Load pointer and hold flags; a read resets them, and a capture in the same cycle then counts as the first capture
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            load_ptr <= 1'b0;
            upper_held <= 1'b0;
            lower_held <= 1'b0;
        end else if (reg_rd) begin
            load_ptr <= cap_ok;
            upper_held <= 1'b0;
            lower_held <= cap_ok;
        end else if (cap_ok) begin
            load_ptr <= !load_ptr;
            if (load_ptr) begin
                upper_held <= 1'b1;
            end else begin
                lower_held <= 1'b1;
            end
        end
    end

    // Upper check-bit field, read-only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            upper_chk <= 7'h00;
        end else if (cap_ok && load_ptr && !upper_held && !reg_rd) begin
            upper_chk <= chk_cap.check;
        end
    end

    // Lower check-bit field: substitute on write, capture on read
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lower_chk <= 7'h00;
        end else if (cap_ok && !load_ptr && (!lower_held || reg_rd)) begin
            lower_chk <= chk_cap.check;
        end else if (cap_ok && reg_rd) begin
            lower_chk <= chk_cap.check;
        end else if (reg_wr) begin
            lower_chk <= bus_req.wdata[`LOWER_HI:`LOWER_LO];
        end
    end

    // Check bits sent with each memory write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_check <= 7'h00;
            wr_check_valid <= 1'b0;
        end else begin
            wr_check_valid <= mem_wr.valid;
            if (mem_wr.valid) begin
                if (diag_mode) begin
                    wr_check <= mem_wr.parity_err ? (lower_chk ^ `PARITY_FLIP)
                                                  : lower_chk;
                end else begin
                    wr_check <= mem_wr.gen_check;
                end
            end
        end
    end

    // Mode outputs toward the array controller and interface timing
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fast_test_select_out <= 1'b0;
            second_pass_out <= 1'b0;
            cache_resp_cycles <= `CACHE_FAST_CYC;
            mem_timer_limit <= 8'h00;
        end else begin
            fast_test_select_out <= fast_test;
            second_pass_out <= fast_test && second_pass;
            cache_resp_cycles <= cache_slow ? `CACHE_SLOW_CYC : `CACHE_FAST_CYC;
            mem_timer_limit <= timer_sel ? 8'(2 * MEM_TIMER_BASE)
                                         : 8'(MEM_TIMER_BASE);
        end
    end

    // Correctable error routing by the soft logging enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            soft_error_irq_n <= 1'b1;
            ce_log <= 1'b0;
            ce_lost <= 1'b0;
        end else begin
            soft_error_irq_n <= !(ce_event && soft_log);
            ce_log <= ce_event && soft_log;
            ce_lost <= ce_event && !soft_log;
        end
    end

    // Timeout limit from the prescaler code
    always_comb begin
        case (prescale)
            2'h3: epr_limit = 20'(EPR_CYC_11);
            2'h2: epr_limit = 20'(EPR_CYC_10);
            2'h1: epr_limit = 20'(EPR_CYC_01);
            default: epr_limit = 20'(EPR_CYC_00);
        endcase
    end

    // External register access timeout
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            epr_state <= EPR_IDLE_S;
            epr_count <= 20'h00000;
            epr_timeout <= 1'b0;
        end else begin
            epr_timeout <= 1'b0;
            case (epr_state)
                EPR_IDLE_S: begin
                    epr_count <= 20'h00000;
                    if (epr_start) begin
                        epr_state <= EPR_WAIT_S;
                    end
                end
                EPR_WAIT_S: begin
                    epr_count <= epr_count + 20'h00001;
                    if (epr_done) begin
                        epr_state <= EPR_IDLE_S;
                    end else if (epr_count + 20'h00001 >= epr_limit) begin
                        epr_timeout <= 1'b1;
                        epr_state <= EPR_IDLE_S;
                    end
                end
                default: epr_state <= EPR_IDLE_S;
            endcase
        end
    end
    assign epr_busy = (epr_state == EPR_WAIT_S);

    // Checks on the behaviour above
    reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
        rdata_valid |-> !rdata[`RSVD_BIT])
        else $error("reserved bit read nonzero");
    read_data_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rd |=> rdata_valid && rdata == $past(reg_view))
        else $error("read data does not match register");
    subst_check_a: assert property (@(posedge clk) disable iff (!rst_b)
        mem_wr.valid && diag_mode && !mem_wr.parity_err |=> wr_check == $past(lower_chk))
        else $error("substitute check bits not sent");
    parity_flip_a: assert property (@(posedge clk) disable iff (!rst_b)
        mem_wr.valid && diag_mode && mem_wr.parity_err
        |=> wr_check == ($past(lower_chk) ^ `PARITY_FLIP))
        else $error("parity error did not invert check bits");
    gen_check_a: assert property (@(posedge clk) disable iff (!rst_b)
        mem_wr.valid && !diag_mode |=> wr_check == $past(mem_wr.gen_check))
        else $error("generated check bits not sent");
    masked_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        chk_cap.valid && chk_cap.masked && !reg_wr && !reg_rd
        |=> $stable(upper_chk) && $stable(lower_chk) && $stable(load_ptr))
        else $error("masked write latched check bits");
    ptr_read_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rd && !chk_cap.valid |=> !load_ptr)
        else $error("read did not reset load pointer");
    upper_load_a: assert property (@(posedge clk) disable iff (!rst_b)
        cap_ok && load_ptr && !upper_held && !reg_rd |=> upper_chk == $past(chk_cap.check))
        else $error("upper field not loaded");
    second_pass_a: assert property (@(posedge clk) disable iff (!rst_b)
        second_pass_out == $past(fast_test && second_pass))
        else $error("second pass output wrong");
    soft_log_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce_event && !soft_log |=> ce_lost && soft_error_irq_n && !ce_log)
        else $error("disabled logging still reported");
    epr_bound_a: assert property (@(posedge clk) disable iff (!rst_b)
        epr_busy |-> epr_count < epr_limit)
        else $error("timeout counter passed its limit");

    // Checks on field loading, mode outputs and pulse routing
    lower_load_a: assert property (@(posedge clk) disable iff (!rst_b)
        cap_ok && !load_ptr && !lower_held && !reg_rd |=> lower_chk == $past(chk_cap.check))
        else $error("lower field not loaded");
    upper_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        upper_held && !reg_rd |=> $stable(upper_chk))
        else $error("held upper field changed");
    ptr_toggle_a: assert property (@(posedge clk) disable iff (!rst_b)
        cap_ok && !reg_rd |=> load_ptr != $past(load_ptr))
        else $error("load pointer did not advance");
    upper_ro_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_wr && !cap_ok |=> $stable(upper_chk))
        else $error("write changed upper field");
    lower_write_a: assert property (@(posedge clk) disable iff (!rst_b)
        reg_wr && !cap_ok |=> lower_chk == $past(bus_req.wdata[`LOWER_HI:`LOWER_LO]))
        else $error("substitute field not written");
    wr_valid_a: assert property (@(posedge clk) disable iff (!rst_b)
        mem_wr.valid |=> wr_check_valid)
        else $error("write check bits not strobed");
    rdata_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        !reg_rd |=> $stable(rdata))
        else $error("read data changed without a read");
    fast_select_a: assert property (@(posedge clk) disable iff (!rst_b)
        fast_test_select_out == $past(fast_test))
        else $error("fast test select does not follow its bit");
    cache_cycles_a: assert property (@(posedge clk) disable iff (!rst_b)
        cache_resp_cycles == ($past(cache_slow) ? `CACHE_SLOW_CYC : `CACHE_FAST_CYC))
        else $error("cache response cycles wrong");
    timer_double_a: assert property (@(posedge clk) disable iff (!rst_b)
        timer_sel |=> mem_timer_limit == 8'(2 * MEM_TIMER_BASE))
        else $error("timer limit not stretched");
    irq_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
        ce_event && soft_log |=> !soft_error_irq_n && ce_log && !ce_lost)
        else $error("enabled logging did not report");
    epr_done_a: assert property (@(posedge clk) disable iff (!rst_b)
        epr_busy && epr_done |=> !epr_busy && !epr_timeout)
        else $error("completed access still timed");
endmodule : memory_mode_diag_control

/* inc/mode_diag_params.svh */
/*
 * Constants for the memory mode and diagnostic control register.
 * Assumes a 20 MHz controller clock; no other file is needed.
 */
`ifndef MODE_DIAG_PARAMS_SVH
`define MODE_DIAG_PARAMS_SVH
`define MODE_DIAG_ADDR 32'h2008_0190
`define DIAG_MODE_BIT 31
`define RSVD_BIT 30
`define UPPER_HI 29
`define UPPER_LO 23
`define LOWER_HI 22
`define LOWER_LO 16
`define FAST_TEST_BIT 15
`define SECOND_PASS_BIT 14
`define CACHE_SPEED_BIT 13
`define TIMER_SEL_BIT 12
`define SOFT_LOG_BIT 11
`define PRESCALE_HI 10
`define PRESCALE_LO 9
`define PARITY_FLIP 7'h07
`define CLK_PERIOD_NS 50
`define EPR_T11_NS 1500
`define EPR_T10_NS 12000
`define EPR_T01_NS 32000
`define EPR_T00_NS 910000
`define NS_TO_CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CACHE_FAST_CYC 2'h1
`define CACHE_SLOW_CYC 2'h2
`endif

/* inc/mode_diag_pkg.sv */
/*
 * Types for the memory mode and diagnostic control register.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mode_diag_pkg;
    // Register access from the processor bus
    typedef struct packed {
        logic sel;
        logic write;
        logic read;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bus_req_type;
    // Memory write transaction going out
    typedef struct packed {
        logic valid;
        logic masked;
        logic parity_err;
        logic [6:0] gen_check;
    } mem_wr_type;
    // Check bits returned by a memory or signature read
    typedef struct packed {
        logic valid;
        logic masked;
        logic [6:0] check;
    } chk_cap_type;
endpackage : mode_diag_pkg

/* verification/memory_array_model.sv */
/*
 * Behavioural model of the memory array side: keeps the last check bits
 * written and returns them as a read capture on request.
 * Assumes the bench pulses read_go just after a rising clock edge.
 */
`timescale 1ns/1ps
module memory_array_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [6:0] wr_check,
    input wire logic wr_check_valid,
    input wire logic read_go,
    input wire logic read_masked,
    output mode_diag_pkg::chk_cap_type chk_cap
);
    logic [6:0] stored_check;

    // Keep check bits as they land in the array
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stored_check <= 7'h00;
        end else if (wr_check_valid) begin
            stored_check <= wr_check;
        end
    end

    // Return stored bits for one cycle, otherwise show a changing pattern
    always_ff @(posedge clk) begin
        chk_cap.valid <= read_go;
        chk_cap.masked <= read_masked;
        chk_cap.check <= read_go ? stored_check : ~chk_cap.check;
    end
endmodule : memory_array_model

/* verification/testbench.sv */
/*
 * Self-checking bench for the mode and diagnostic control register.
 * Assumes the register is reached only through bus_req one-cycle strobes.
 */
`timescale 1ns/1ps
module testbench;
    localparam logic [31:0] reg_addr = 32'h2008_0190;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    mode_diag_pkg::bus_req_type bus_req = '0;
    mode_diag_pkg::mem_wr_type mem_wr = '0;
    mode_diag_pkg::chk_cap_type chk_cap;
    logic [31:0] rdata;
    logic [6:0] wr_check;
    logic [1:0] cache_resp_cycles;
    logic [7:0] mem_timer_limit;
    logic rdata_valid, wr_check_valid, fast_test_select_out, second_pass_out;
    logic soft_error_irq_n, ce_log, ce_lost, epr_busy, epr_timeout;
    logic ce_event = 1'b0;
    logic epr_start = 1'b0;
    logic epr_done = 1'b0;
    logic read_go = 1'b0;
    logic read_masked = 1'b0;
    int fails = 0;
    int comparisons = 0;

    memory_mode_diag_control #(.EPR_CYC_00(50)) uut (.clk(clk), .rst_b(rst_b),
        .bus_req(bus_req), .rdata(rdata), .rdata_valid(rdata_valid), .mem_wr(mem_wr),
        .wr_check(wr_check), .wr_check_valid(wr_check_valid), .chk_cap(chk_cap),
        .fast_test_select_out(fast_test_select_out), .second_pass_out(second_pass_out),
        .cache_resp_cycles(cache_resp_cycles), .mem_timer_limit(mem_timer_limit),
        .ce_event(ce_event), .soft_error_irq_n(soft_error_irq_n), .ce_log(ce_log),
        .ce_lost(ce_lost), .epr_start(epr_start), .epr_done(epr_done),
        .epr_busy(epr_busy), .epr_timeout(epr_timeout));

    memory_array_model array_model (.clk(clk), .rst_b(rst_b), .wr_check(wr_check),
        .wr_check_valid(wr_check_valid), .read_go(read_go), .read_masked(read_masked),
        .chk_cap(chk_cap));

    // Clock at 20 MHz
    always #25 clk = ~clk;

    // Compare one value and count it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Advance n edges and settle just after the last one
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // One register access; a read also checks its answer strobe
    task automatic reg_access(input logic wr, input logic [31:0] addr,
                              input logic [31:0] wd, output logic [31:0] rd);
        bus_req = {1'b1, wr, ~wr, addr, wd};
        step(1);
        bus_req = '0;
        rd = rdata;
        if (!wr) check({31'h0, rdata_valid}, 32'h1);
        step(1); // Idle edge before the next access
    endtask : reg_access

    // One memory write and the check bits that go out with it
    task automatic mem_write(input logic masked, input logic par, input logic [6:0] gen,
                             input logic [6:0] exp);
        mem_wr = {1'b1, masked, par, gen};
        step(1);
        mem_wr = '0;
        check({31'h0, wr_check_valid}, 32'h1);
        check({25'h0, wr_check}, {25'h0, exp});
        step(1); // Idle edge before the next write
    endtask : mem_write

    // Ask the array for a read capture
    task automatic capture(input logic masked);
        read_go = 1'b1;
        read_masked = masked;
        step(1);
        read_go = 1'b0;
        step(1);
    endtask : capture

    // Reset image and output levels
    task automatic t_reset;
        logic [31:0] d;
        reg_access(1'b0, reg_addr, 32'h0, d);
        check(d, 32'h0);
        check({soft_error_irq_n, cache_resp_cycles, mem_timer_limit}, {1'h1, 2'h1, 8'h04});
        $display("reset test done");
    endtask : t_reset

    // Writable bits, reserved bit, foreign address and mode outputs
    task automatic t_image;
        logic [31:0] d;
        reg_access(1'b1, 32'h2008_0194, 32'hffff_ffff, d);
        reg_access(1'b0, reg_addr, 32'h0, d);
        check(d, 32'h0);
        reg_access(1'b1, reg_addr, 32'hffff_ffff, d);
        reg_access(1'b0, reg_addr, 32'h0, d);
        check(d, 32'h807f_fe00);
        step(2);
        check({fast_test_select_out, second_pass_out}, 32'h3);
        check({cache_resp_cycles, mem_timer_limit}, {2'h2, 8'h08});
        reg_access(1'b1, reg_addr, 32'h0000_4000, d);
        step(2);
        check({fast_test_select_out, second_pass_out}, 32'h0);
        check({cache_resp_cycles, mem_timer_limit}, {2'h1, 8'h04});
        $display("image test done");
    endtask : t_image

    // Check-bit substitution, parity inversion and plain generated bits
    task automatic t_substitute;
        logic [31:0] d;
        reg_access(1'b1, reg_addr, 32'h8055_0000, d);
        mem_write(1'b0, 1'b0, 7'h12, 7'h55);
        mem_write(1'b0, 1'b1, 7'h12, 7'h52);
        mem_write(1'b1, 1'b0, 7'h12, 7'h55);
        mem_write(1'b1, 1'b1, 7'h12, 7'h52);
        reg_access(1'b1, reg_addr, 32'h0, d);
        mem_write(1'b0, 1'b1, 7'h12, 7'h12);
        $display("substitute test done");
    endtask : t_substitute

    // Load pointer order, masked capture ignored, pointer reset by a read
    task automatic t_capture;
        logic [31:0] d;
        mem_write(1'b0, 1'b0, 7'h11, 7'h11);
        reg_access(1'b0, reg_addr, 32'h0, d);
        capture(1'b0);
        capture(1'b1);
        mem_write(1'b0, 1'b0, 7'h22, 7'h22);
        capture(1'b0);
        reg_access(1'b0, reg_addr, 32'h0, d);
        check({18'h0, d[29:16]}, {18'h0, 7'h22, 7'h11});
        capture(1'b0);
        reg_access(1'b0, reg_addr, 32'h0, d);
        check({25'h0, d[22:16]}, 32'h22);
        $display("capture test done");
    endtask : t_capture

    // Correctable error with logging on or off
    task automatic t_soft(input logic en);
        logic [31:0] d;
        logic irq, lg, lost;
        reg_access(1'b1, reg_addr, {20'h0, en, 11'h0}, d);
        irq = 1'b0;
        lg = 1'b0;
        lost = 1'b0;
        ce_event = 1'b1;
        repeat (2) begin
            step(1);
            ce_event = 1'b0;
            irq |= ~soft_error_irq_n;
            lg |= ce_log;
            lost |= ce_lost;
        end
        check({29'h0, irq, lg, lost}, {29'h0, en, en, ~en});
        $display("soft error test done");
    endtask : t_soft

    // Timeout span for one prescaler code, then an access that completes
    task automatic t_epr(input logic [1:0] code, input int span);
        logic [31:0] d;
        int cnt;
        reg_access(1'b1, reg_addr, {21'h0, code, 9'h0}, d);
        epr_start = 1'b1;
        step(1);
        epr_start = 1'b0;
        cnt = 1;
        check({31'h0, epr_busy}, 32'h1);
        while (epr_timeout !== 1'b1 && cnt < 1000) begin
            step(1);
            cnt++;
        end
        check(cnt - 1, span);
        epr_start = 1'b1;
        step(1);
        epr_start = 1'b0;
        step(4);
        epr_done = 1'b1;
        step(1);
        epr_done = 1'b0;
        cnt = 0;
        repeat (span + 4) begin
            step(1);
            cnt += epr_timeout;
        end
        check({cnt[30:0], epr_busy}, 32'h0);
        $display("timeout test done");
    endtask : t_epr

    // Mid-run power-up clear acts without waiting for an edge
    task automatic t_async;
        logic [31:0] d;
        reg_access(1'b1, reg_addr, 32'h8000_8000, d);
        step(1);
        check({31'h0, fast_test_select_out}, 32'h1);
        rst_b = 1'b0;
        #1;
        check({31'h0, fast_test_select_out}, 32'h0);
        step(2);
        rst_b = 1'b1;
        step(1);
        reg_access(1'b0, reg_addr, 32'h0, d);
        check(d, 32'h0);
        $display("async reset test done");
    endtask : t_async

    // Print counts and verdict, then stop
    task automatic end_of_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    // Watchdog well beyond the expected run of a few thousand cycles
    initial begin
        #(50 * 20000);
        fails++;
        end_of_test();
    end

    // Main sequence
    initial begin
        step(4);
        rst_b = 1'b1;
        step(1);
        t_reset();
        t_image();
        t_async();
        t_substitute();
        t_capture();
        t_soft(1'b1);
        t_soft(1'b0);
        t_epr(2'h3, 30);
        t_epr(2'h2, 240);
        t_epr(2'h1, 640);
        t_epr(2'h0, 50);
        end_of_test();
    end
endmodule : testbench
